//--- hw/cpr_regs.sv
// Prefix, fetch pointer and stack pointer registers with AHB-Lite access
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module cpr_regs
    import cpr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire cpr_exec_t   exec_in,
    output cpr_view_t        view_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  prefix_reg;
    logic        prefix_live_reg;
    logic [2:0]  ext_src_next;
    logic [2:0]  ext_dst_next;
    logic [15:0] fetch_reg;
    logic [15:0] fetch_next;
    logic        ph_wr_reg;
    logic        ph_rd_reg;
    logic [3:0]  ph_idx_reg;
    logic        bus_wr_prefix;
    logic        bus_wr_fetch;
    logic        bus_wr_stack;
    logic        any_wr_prefix;
    logic        any_wr_stack;
    logic [15:0] prefix_wr_val;
    logic [15:0] fetch_wr_val;
    logic [15:0] stack_wr_val;
    logic [15:0] sp_value;
    logic [15:0] prefix_value;
    logic [31:0] rd_value;
    logic        fetch_count_reg;

    function automatic logic [3:0] word_index(input logic [31:0] a);
        word_index = a[5:2];
    endfunction

    // Datapath data wins over bus data for the register that it writes
    function automatic logic [15:0] write_source(input logic        dp_wr,
                                                 input logic [15:0] dp_data,
                                                 input logic [15:0] bus_data);
        write_source = dp_wr ? dp_data : bus_data;
    endfunction

    // Stack pointer value after this edge, so the view shows what the next cycle sees
    function automatic logic [15:0] stack_after(input logic [15:0] cur,
                                                input logic        wr,
                                                input logic [15:0] wd,
                                                input logic        psh,
                                                input logic        pp);
        logic [CPR_SP_W-1:0] s;
        s = cur[CPR_SP_W-1:0];
        if (wr) begin
            s = wd[CPR_SP_W-1:0];
        end else if (psh && !pp) begin
            s = s + CPR_SP_W'(1);
        end else if (pp && !psh) begin
            s = s - CPR_SP_W'(1);
        end
        stack_after = {{(16-CPR_SP_W){1'b0}}, s};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_reg  <= 1'b0;
            ph_rd_reg  <= 1'b0;
            ph_idx_reg <= 4'h0;
        end else if (hready) begin
            ph_wr_reg  <= hsel && htrans == CPR_HTRANS_NSQ && hwrite && hsize == 3'h2;
            ph_rd_reg  <= hsel && htrans == CPR_HTRANS_NSQ && !hwrite;
            ph_idx_reg <= word_index(haddr);
        end
    end

    assign bus_wr_prefix = ph_wr_reg && ph_idx_reg == word_index(CPR_OFS_PREFIX);
    assign bus_wr_fetch  = ph_wr_reg && ph_idx_reg == word_index(CPR_OFS_FETCH);
    assign bus_wr_stack  = ph_wr_reg && ph_idx_reg == word_index(CPR_OFS_STACK);

    // Datapath writes win over bus writes in the same cycle
    assign any_wr_prefix = exec_in.wr_prefix || bus_wr_prefix;
    assign any_wr_stack  = exec_in.wr_stack || bus_wr_stack;
    assign prefix_wr_val = write_source(exec_in.wr_prefix, exec_in.wdata, hwdata[15:0]);
    assign fetch_wr_val  = write_source(exec_in.wr_fetch, exec_in.wdata, hwdata[15:0]);
    assign stack_wr_val  = write_source(exec_in.wr_stack, exec_in.wdata, hwdata[15:0]);

    ////////////////////////////////////////////////////////////////////////
    // Prefix: live for exactly one cycle after a load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prefix_reg      <= CPR_PREFIX_RST[CPR_PFX_W-1:0]; // RQ1
            prefix_live_reg <= 1'b0;
        end else if (any_wr_prefix && (!exec_in.wr_prefix || exec_in.prefix_sub == 3'h0)) begin
            prefix_reg      <= prefix_wr_val[CPR_PFX_LSB +: CPR_PFX_W]; // RQ14
            prefix_live_reg <= 1'b1;
        end else begin
            prefix_reg      <= 8'h00; // RQ3
            prefix_live_reg <= 1'b0;
        end
    end

    // Index extension bits from subdecodes 1 to 7, shown for the next cycle only
    always_comb begin
        ext_src_next = 3'h0;
        ext_dst_next = 3'h0;
        if (exec_in.wr_prefix && exec_in.prefix_sub != 3'h0) begin
            ext_src_next = exec_in.wdata[CPR_EXT_W-1:0]; // RQ6
            ext_dst_next = exec_in.wdata[CPR_EXT_W+3:4]; // RQ6
        end
    end

    assign prefix_value = prefix_live_reg ? {8'h00, prefix_reg} : 16'h0000; // RQ4 RQ5

    ////////////////////////////////////////////////////////////////////////
    // Fetch pointer: write redirects, otherwise count fetches
    always_comb begin
        fetch_next = fetch_reg;
        if (exec_in.wr_fetch || bus_wr_fetch) begin
            fetch_next = fetch_wr_val; // RQ9
        end else if (exec_in.fetch) begin
            fetch_next = fetch_reg + 16'h0001; // RQ8
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_reg <= CPR_FETCH_RST; // RQ7
        end else begin
            fetch_reg <= fetch_next; // RQ14
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_count_reg <= 1'b0;
        end else begin
            fetch_count_reg <= exec_in.fetch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cpr_stack_ptr u_stack (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .wr_en    (any_wr_stack),
        .wdata    (stack_wr_val),
        .push     (exec_in.push),
        .pop      (exec_in.pop),
        .sp_value (sp_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register view to the datapath
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            view_out <= '0;
        end else begin
            view_out.joined     <= {prefix_value[7:0], exec_in.src_low}; // RQ2
            view_out.prefix_rd  <= prefix_value; // RQ4
            view_out.fetch_addr <= fetch_next; // RQ10
            view_out.stack_rd   <= stack_after(sp_value, any_wr_stack, stack_wr_val,
                                               exec_in.push, exec_in.pop); // RQ12 RQ13
            view_out.src_ext    <= ext_src_next; // RQ6
            view_out.dst_ext    <= ext_dst_next; // RQ6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus read data, one wait state in each read data phase
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (ph_idx_reg)
            word_index(CPR_OFS_PREFIX): rd_value = {16'h0000, prefix_value}; // RQ5
            word_index(CPR_OFS_FETCH):  rd_value = {16'h0000, fetch_reg}; // RQ10
            word_index(CPR_OFS_STACK):  rd_value = {16'h0000, sp_value}; // RQ12
            word_index(CPR_OFS_STATUS): rd_value = {30'h0000_0000, fetch_count_reg,
                                                    prefix_live_reg};
            default:                    rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == CPR_HTRANS_NSQ && !hwrite) begin
            hrdata <= 32'h0000_0000;
        end else if (ph_rd_reg) begin
            hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(hready && hsel && htrans == CPR_HTRANS_NSQ && !hwrite);
            hresp     <= 1'b0;
        end
    end
endmodule

//--- hw/cpr_pkg.sv
// Constants and carrier types for the core prefix and pointer register block
// Contract
// RQ1: Prefix register clears to zero on reset
// RQ2: Prefix byte joins above next 8-bit source
// RQ3: Prefix holds one cycle, then clears itself
// RQ4: Unloaded prefix read as source gives zero
// RQ5: Prefix upper eight bits read as zero
// RQ6: Prefix subdecodes 1-7 extend register index
// RQ7: Fetch pointer loads start address on reset
// RQ8: Fetch pointer advances by one per fetch
// RQ9: Writing fetch pointer redirects program fetch
// RQ10: Reading fetch pointer leaves flow unchanged
// RQ11: Stack pointer set to initial value on reset
// RQ12: Stack pointer uses six bits, rest zero
// RQ13: Push preincrements, pop postdecrements stack pointer
// RQ14: Writes take effect for the next instruction
package cpr_pkg;
    localparam logic [31:0] CPR_OFS_PREFIX  = 32'h0000_0000;
    localparam logic [31:0] CPR_OFS_FETCH   = 32'h0000_0004;
    localparam logic [31:0] CPR_OFS_STACK   = 32'h0000_0008;
    localparam logic [31:0] CPR_OFS_STATUS  = 32'h0000_000C;
    localparam logic [15:0] CPR_PREFIX_RST  = 16'h0000;
    localparam logic [15:0] CPR_FETCH_RST   = 16'h8000;
    localparam logic [15:0] CPR_STACK_RST   = 16'h002F;
    localparam int          CPR_PFX_LSB     = 0;
    localparam int          CPR_PFX_W       = 8;
    localparam int          CPR_SP_W        = 6;
    localparam int          CPR_EXT_W       = 3;
    localparam logic [1:0]  CPR_HTRANS_NSQ  = 2'h2;

    // Register accesses from the execute datapath in one instruction cycle
    typedef struct packed {
        logic        wr_prefix;
        logic [2:0]  prefix_sub;
        logic        wr_fetch;
        logic        wr_stack;
        logic [15:0] wdata;
        logic [7:0]  src_low;
        logic        fetch;
        logic        push;
        logic        pop;
    } cpr_exec_t;

    // Values handed back to the datapath and fetch unit
    typedef struct packed {
        logic [15:0] joined;
        logic [15:0] prefix_rd;
        logic [15:0] fetch_addr;
        logic [15:0] stack_rd;
        logic [2:0]  src_ext;
        logic [2:0]  dst_ext;
    } cpr_view_t;
endpackage

//--- hw/cpr_stack_ptr.sv
// Stack top pointer with push and pop adjustment
`timescale 1ns/10ps
module cpr_stack_ptr
    import cpr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    input  wire logic        push,
    input  wire logic        pop,
    output logic [15:0]      sp_value
);
    logic [CPR_SP_W-1:0] sp_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_reg <= CPR_STACK_RST[CPR_SP_W-1:0]; // RQ11
        end else if (wr_en) begin
            sp_reg <= wdata[CPR_SP_W-1:0]; // RQ14
        end else if (push && !pop) begin
            sp_reg <= sp_reg + 6'h01; // RQ13
        end else if (pop && !push) begin
            sp_reg <= sp_reg - 6'h01; // RQ13
        end
    end

    assign sp_value = {10'h000, sp_reg}; // RQ12
endmodule

//--- tb/cpr_regs_props.sv
// Checker of the prefix and pointer register block
`timescale 1ns/10ps
module cpr_regs_props
    import cpr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire cpr_exec_t   exec_in,
    input wire cpr_view_t   view_out
);
    // Bus write data phase per register: stack, fetch, prefix
    logic [2:0] dw_q;
    always_ff @(posedge hclk)
        dw_q <= {3{hsel && hready && htrans == CPR_HTRANS_NSQ && hwrite}}
            & {haddr == CPR_OFS_STACK, haddr == CPR_OFS_FETCH, haddr == CPR_OFS_PREFIX};
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_reset_view: assert property ($rose(hresetn) && exec_in == '0 |=>
        view_out.fetch_addr == CPR_FETCH_RST && view_out.stack_rd == CPR_STACK_RST)
        else $error("reset view");
    a_join_byte: assert property ((exec_in.wr_prefix && exec_in.prefix_sub == 3'h0) ##1 1 |=>
        view_out.joined == {$past(exec_in.wdata[7:0], 2), $past(exec_in.src_low)}) else $error("join");
    a_join_zero: assert property ((!dw_q[0] && !exec_in.wr_prefix) ##1 1 |=>
        view_out.joined[15:8] == 8'h00) else $error("stale prefix");
    a_upper_zero: assert property (
        view_out.prefix_rd[15:8] == 8'h00 && view_out.stack_rd[15:6] == 10'h000) else $error("upper");
    a_sub_ext: assert property (exec_in.wr_prefix && exec_in.prefix_sub != 3'h0 |=>
        {view_out.dst_ext, view_out.src_ext} == {$past(exec_in.wdata[6:4]), $past(exec_in.wdata[2:0])})
        else $error("extension");
    a_fetch_step: assert property (exec_in.fetch && !exec_in.wr_fetch && !dw_q[1] && $past(hresetn) |=>
        view_out.fetch_addr == $past(view_out.fetch_addr) + 16'h0001) else $error("fetch step");
    a_fetch_load: assert property (exec_in.wr_fetch |=>
        view_out.fetch_addr == $past(exec_in.wdata)) else $error("fetch load");
    a_stack_push: assert property (exec_in.push && !exec_in.pop && !exec_in.wr_stack && !dw_q[2]
        && $past(hresetn) |=> view_out.stack_rd[5:0] == $past(view_out.stack_rd[5:0]) + 6'h01)
        else $error("push");
    a_stack_pop: assert property (exec_in.pop && !exec_in.push && !exec_in.wr_stack && !dw_q[2]
        && $past(hresetn) |=> view_out.stack_rd[5:0] == $past(view_out.stack_rd[5:0]) - 6'h01)
        else $error("pop");
endmodule
bind cpr_regs cpr_regs_props u_cpr_regs_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .exec_in, .view_out);

//--- tb/cpr_dp_model.sv
// Execute datapath model issuing one request set per instruction cycle
`timescale 1ns/10ps
module cpr_dp_model
    import cpr_pkg::*;
(
    input wire logic hclk,
    output cpr_exec_t exec_out
);
    initial exec_out = '0;
    task automatic step(input cpr_exec_t s, input int n);
        exec_out <= s;
        repeat (n) @(posedge hclk);
    endtask
endmodule

//--- tb/cpr_regs_tb.sv
// Testbench of the prefix and pointer register block
`timescale 1ns/10ps
module cpr_regs_tb
    import cpr_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    cpr_exec_t   x;
    cpr_view_t   v;
    int          errors = 0, checks = 0, cyc = 0;
    always #50 hclk = ~hclk;
    cpr_dp_model u_cpr_dp_model (.hclk, .exec_out(x));
    cpr_regs u_cpr_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .exec_in(x), .view_out(v));
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        haddr <= a;
        htrans <= CPR_HTRANS_NSQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(n, exp, d);
        chk("resp", 32'h0, {31'h0, hresp});
    endtask
    task automatic finish_test(input int late);
        errors += late;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge hclk) if (++cyc == 1500) finish_test(1);
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        u_cpr_dp_model.step('0, 2);
        chk("fetch", CPR_FETCH_RST, v.fetch_addr);
        chk("stack", CPR_STACK_RST, v.stack_rd);
        rd("unmapped", 32'h0000_0010, 32'h0);
        rd("status", CPR_OFS_STATUS, 32'h0);
        u_cpr_dp_model.step('{fetch: 1'b1, default: '0}, 3);
        u_cpr_dp_model.step('0, 1);
        chk("fetch", 16'h8003, v.fetch_addr);
        rd("rd fetch", CPR_OFS_FETCH, 32'h0000_8003);
        chk("fetch", 16'h8003, v.fetch_addr);
        bus(1'b1, CPR_OFS_FETCH, 32'hFFFF_ABCD);
        rd("rd fetch", CPR_OFS_FETCH, 32'h0000_ABCD);
        u_cpr_dp_model.step('{wr_fetch: 1'b1, wdata: 16'h1234, default: '0}, 1);
        u_cpr_dp_model.step('0, 1);
        chk("fetch", 16'h1234, v.fetch_addr);
        $display("reset and fetch test done");
        u_cpr_dp_model.step('{wr_prefix: 1'b1, wdata: 16'hAB12, default: '0}, 1);
        u_cpr_dp_model.step('{src_low: 8'h34, default: '0}, 1);
        u_cpr_dp_model.step('{src_low: 8'h56, default: '0}, 1);
        chk("joined", 16'h1234, v.joined);
        chk("prefix rd", 32'h0000_0012, v.prefix_rd);
        u_cpr_dp_model.step('0, 1);
        chk("joined", 16'h0056, v.joined);
        rd("rd prefix", CPR_OFS_PREFIX, 32'h0);
        for (int k = 1; k < 8; k++) begin
            u_cpr_dp_model.step('{wr_prefix: 1'b1, prefix_sub: 3'(k), wdata: 16'(k * 17),
                default: '0}, 1);
            u_cpr_dp_model.step('0, 1);
            chk("ext", {3'(k), 3'(k)}, {v.dst_ext, v.src_ext});
        end
        u_cpr_dp_model.step('{push: 1'b1, default: '0}, 2);
        u_cpr_dp_model.step('{pop: 1'b1, default: '0}, 1);
        u_cpr_dp_model.step('0, 1);
        chk("stack", 16'h0030, v.stack_rd);
        bus(1'b1, CPR_OFS_STACK, 32'hFFFF_FFFF);
        rd("rd stack", CPR_OFS_STACK, 32'h0000_003F);
        $display("prefix and stack test done");
        finish_test(0);
    end
endmodule
